// ==== src/cis_defines.vh ====
/*
 constants for the extension base, info space base and info pointer registers.
 assumes inclusion by info_space_base_field_ptr_cfg.v only.
*/
`ifndef CIS_DEFINES_VH
`define CIS_DEFINES_VH
`define CIS_OFS_EXT_BASE 8'h14
`define CIS_OFS_INFO_BASE 8'h18
`define CIS_OFS_INFO_PTR 8'h28
`define INFO_SPACE_BASE_FIELD_LSB 11
`define INFO_SPACE_BASE_FIELD_RESET 21'h000000
`define CIS_PTR_ROM_ZERO 4'h0
`define CIS_OFS_LOAD_LSB 3
`define CIS_OFS_LOAD_MSB 7
`define CIS_IND_STRAP_LOW 3'h2
`define CIS_IND_STRAP_HIGH 3'h0
`define CIS_OFS_UPPER_DEFAULT 20'h00000
`define CIS_STRAP_FILL 2'h2
`define CIS_INFO_SIZE_ZERO 7'h00
`define CIS_INFO_PREFETCH_OFF 1'h0
`define CIS_INFO_LOCATE_ANY32 2'h0
`define CIS_INFO_MEMORY_SPACE 1'h0
`endif

// ==== src/info_space_base_field_ptr_cfg.v ====
/*
 configuration registers for the vendor extension window base, the card
 information space base and the card information pointer, plus window decode
 and the byte path from the info space to the serial rom.
 assumes a configuration port on clk, an active-low reset acting as pci reset,
 and a serial rom loader on clk that presents the offset field and read data.
*/
`include "cis_defines.vh"

module info_space_base_field_ptr_cfg #(
    parameter [19:0] OFS_UPPER = `CIS_OFS_UPPER_DEFAULT
) (
    input wire clk,
    input wire rst_b,
    input wire busModeStrap,
    input wire cfgWrite,
    input wire cfgRead,
    input wire [7:0] cfgAddr,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgWrData,
    output reg [31:0] cfgRdData,
    input wire [4:0] romOffsetField,
    input wire romOffsetValid,
    input wire memRead,
    input wire [31:0] memAddr,
    output wire extWindowHit,
    output wire infoSpaceHit,
    output wire romReadReq,
    output wire [7:0] romAddr,
    input wire romDataValid,
    input wire [7:0] romData,
    output reg memDataValid,
    output reg [7:0] memData
);
    // rom request path: idle, or waiting for the rom byte
    localparam [0:0] ROM_IDLE = 1'b0;
    localparam [0:0] ROM_WAIT = 1'b1;

    reg strapMeta_ff;
    reg strapSync_ff;
    reg [1:0] strapFill_ff;
    reg strapLatched_ff;
    reg strapTaken_ff;
    reg [20:0] extBase_ff;
    reg [20:0] infoBase_ff;
    reg [4:0] romOffset_ff;
    reg [7:0] romAddr_ff;
    reg romState_ff;
    reg nxt_romState;
    reg [31:0] nxt_cfgRdData;
    wire addrIsExt;
    wire addrIsInfo;
    wire addrIsPtr;
    wire writeHitExt;
    wire writeHitInfo;
    wire [20:0] laneEn;
    wire [20:0] nxt_extBase;
    wire [20:0] nxt_infoBase;
    wire [6:0] infoSpaceSizeField;
    wire infoSpacePrefetchBit;
    wire [1:0] infoSpaceLocateType;
    wire infoSpaceMemoryIndicator;
    wire [10:0] lowBaseBits;
    wire [3:0] ptrTopBits;
    wire [24:0] structureOffsetField;
    wire [2:0] spaceIndicatorField;
    wire [31:0] extBaseRd;
    wire [31:0] infoBaseRd;
    wire [31:0] infoPtrRd;
    wire extTagMatch;
    wire infoTagMatch;
    wire infoBaseSet;
    wire romTake;
    wire romDone;
    genvar b;

    // strap caught only once the sync pair holds the pin, else the reset zero is latched
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strapMeta_ff <= 1'b0;
            strapSync_ff <= 1'b0;
            strapFill_ff <= 2'h0;
            strapLatched_ff <= 1'b0;
            strapTaken_ff <= 1'b0;
        end else begin
            strapMeta_ff <= busModeStrap;
            strapSync_ff <= strapMeta_ff;
            if (strapFill_ff != `CIS_STRAP_FILL) begin
                strapFill_ff <= strapFill_ff + 2'h1;
            end
            if (!strapTaken_ff && (strapFill_ff == `CIS_STRAP_FILL)) begin
                strapLatched_ff <= strapSync_ff;
                strapTaken_ff <= 1'b1;
            end
        end
    end

    assign addrIsExt = (cfgAddr == `CIS_OFS_EXT_BASE);
    assign addrIsInfo = (cfgAddr == `CIS_OFS_INFO_BASE);
    assign addrIsPtr = (cfgAddr == `CIS_OFS_INFO_PTR);
    assign writeHitExt = cfgWrite && addrIsExt;
    assign writeHitInfo = cfgWrite && addrIsInfo && !strapLatched_ff;

    // byte enables steer the writable bits; byte 1 holds only bits 15-11
    generate
        for (b = 0; b < 21; b = b + 1) begin : g_wr
            assign laneEn[b] = cfgByteEn[(b + `INFO_SPACE_BASE_FIELD_LSB) / 8];
            assign nxt_extBase[b] = (writeHitExt && laneEn[b]) ?
                cfgWrData[b + `INFO_SPACE_BASE_FIELD_LSB] : extBase_ff[b];
            assign nxt_infoBase[b] = (writeHitInfo && laneEn[b]) ?
                cfgWrData[b + `INFO_SPACE_BASE_FIELD_LSB] : infoBase_ff[b];
        end
    endgenerate

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            extBase_ff <= `INFO_SPACE_BASE_FIELD_RESET;
            infoBase_ff <= `INFO_SPACE_BASE_FIELD_RESET;
            romOffset_ff <= 5'h00;
        end else begin
            extBase_ff <= nxt_extBase;
            infoBase_ff <= strapLatched_ff ? `INFO_SPACE_BASE_FIELD_RESET : nxt_infoBase;
            if (romOffsetValid) begin
                romOffset_ff <= romOffsetField;
            end
        end
    end

    // both bases share one low-bit layout: 2k, nonprefetchable, anywhere in 32 bits, memory
    assign infoSpaceSizeField = `CIS_INFO_SIZE_ZERO;
    assign infoSpacePrefetchBit = `CIS_INFO_PREFETCH_OFF;
    assign infoSpaceLocateType = `CIS_INFO_LOCATE_ANY32;
    assign infoSpaceMemoryIndicator = `CIS_INFO_MEMORY_SPACE;
    assign lowBaseBits = {infoSpaceSizeField, infoSpacePrefetchBit, infoSpaceLocateType, infoSpaceMemoryIndicator};
    assign extBaseRd = {extBase_ff, lowBaseBits};
    assign infoBaseRd = strapLatched_ff ? 32'h00000000 : {infoBase_ff, lowBaseBits};
    assign ptrTopBits = `CIS_PTR_ROM_ZERO;
    assign structureOffsetField = {OFS_UPPER, romOffset_ff};
    assign spaceIndicatorField = strapLatched_ff ? `CIS_IND_STRAP_HIGH : `CIS_IND_STRAP_LOW;
    assign infoPtrRd = strapLatched_ff ? 32'h00000000 :
        {ptrTopBits, structureOffsetField, spaceIndicatorField};

    // unknown offsets read zero; data holds between reads
    always @* begin
        nxt_cfgRdData = cfgRdData;
        if (cfgRead) begin
            if (addrIsExt) begin
                nxt_cfgRdData = extBaseRd;
            end else if (addrIsInfo) begin
                nxt_cfgRdData = infoBaseRd;
            end else if (addrIsPtr) begin
                nxt_cfgRdData = infoPtrRd;
            end else begin
                nxt_cfgRdData = 32'h00000000;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgRdData <= 32'h00000000;
        end else begin
            cfgRdData <= nxt_cfgRdData;
        end
    end

    // a zero info base never decodes, which guards the space until software programs it
    assign extTagMatch = (memAddr[31:`INFO_SPACE_BASE_FIELD_LSB] == extBase_ff);
    assign infoTagMatch = (memAddr[31:`INFO_SPACE_BASE_FIELD_LSB] == infoBase_ff);
    assign infoBaseSet = (infoBase_ff != `INFO_SPACE_BASE_FIELD_RESET);
    assign extWindowHit = extTagMatch;
    assign infoSpaceHit = !strapLatched_ff && infoBaseSet && infoTagMatch;

    assign romTake = memRead && infoSpaceHit && (romState_ff == ROM_IDLE);
    assign romDone = (romState_ff == ROM_WAIT) && romDataValid;

    always @* begin
        nxt_romState = romState_ff;
        case (romState_ff)
            ROM_IDLE: begin
                if (romTake) begin
                    nxt_romState = ROM_WAIT;
                end
            end
            ROM_WAIT: begin
                if (romDone) begin
                    nxt_romState = ROM_IDLE;
                end
            end
            default: begin
                nxt_romState = ROM_IDLE;
            end
        endcase
    end

    // one byte per access; wider reads return just the addressed byte, undefined beyond it
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            romState_ff <= ROM_IDLE;
            romAddr_ff <= 8'h00;
            memDataValid <= 1'b0;
            memData <= 8'h00;
        end else begin
            romState_ff <= nxt_romState;
            memDataValid <= romDone;
            if (romTake) begin
                romAddr_ff <= memAddr[7:0];
            end
            if (romDone) begin
                memData <= romData;
            end
        end
    end

    assign romReadReq = (romState_ff == ROM_WAIT);
    assign romAddr = romAddr_ff;
endmodule // info_space_base_field_ptr_cfg

// ==== tb/cbp_sva.sv ====
/* checker: config read values and the rom byte path.
   assumes binding onto info_space_base_field_ptr_cfg. */
module cbp_sva(input wire clk, rst_b, cfgRead, memRead, infoSpaceHit, romReadReq, romDataValid, memDataValid,
    input wire [7:0] cfgAddr, romAddr, romData, memData, input wire [31:0] cfgRdData, memAddr);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence rdAt(logic [7:0] a); cfgRead && cfgAddr == a; endsequence
    sequence romTaken; memRead && infoSpaceHit && !romReadReq; endsequence
    sequence ptrFixed; cfgRdData[31:28] == 4'h0 && !cfgRdData[2] && !cfgRdData[0]; endsequence
    sequence romIssued; romReadReq && {24'h0, romAddr} == ($past(memAddr) & 32'hFF); endsequence
    sequence byteBack; memDataValid && !romReadReq && memData == $past(romData); endsequence
    ext_low_zero_a: assert property (rdAt(8'h14) |=> cfgRdData[10:0] == 11'h0) else $error("ext low");
    info_low_zero_a: assert property (rdAt(8'h18) |=> cfgRdData[10:0] == 11'h0) else $error("info low");
    ptr_fixed_a: assert property (rdAt(8'h28) |=> ptrFixed) else $error("ptr bits");
    rom_addr_a: assert property (romTaken |=> romIssued) else $error("rom addr");
    rom_hold_a: assert property (romReadReq && !romDataValid |=> romReadReq) else $error("req dropped");
    data_back_a: assert property (romReadReq && romDataValid |=> byteBack) else $error("byte back");
    valid_pulse_a: assert property (memDataValid |=> !memDataValid) else $error("valid long");
    hit_nonzero_a: assert property (infoSpaceHit |-> memAddr[31:11] != 21'h0) else $error("zero base hit");
    addr_hold_a: assert property (romReadReq && !romDataValid |=> $stable(romAddr)) else $error("addr moved");
    valid_cause_a: assert property (memDataValid |-> $past(romReadReq) && $past(romDataValid)) else $error("valid unasked");
endmodule // cbp_sva
bind info_space_base_field_ptr_cfg cbp_sva chk(.*);

// ==== tb/cbp_rom.sv ====
/* serial rom data model: answers a byte request lat+1 cycles after romReadReq rises.
   assumes the requester holds romReadReq until romDataValid. */
module cbp_rom(input wire clk, input wire romReadReq, input wire [7:0] romAddr, input wire [3:0] lat,
    output logic romDataValid = 1'h0, output logic [7:0] romData = 8'h0);
    logic [3:0] waitCnt = 4'h0;
    // idle data keeps moving so a stale byte never passes
    always @(posedge clk) begin
        romDataValid <= 1'h0;
        romData <= romData + 8'h3B;
        if (romReadReq && !romDataValid) begin
            waitCnt <= (waitCnt >= lat) ? 4'h0 : waitCnt + 4'h1;
            if (waitCnt >= lat) begin
                romDataValid <= 1'h1;
                romData <= ~romAddr;
            end
        end
    end
endmodule // cbp_rom

// ==== tb/info_space_base_field_ptr_cfg_tb_top.sv ====
/* testbench for the base and pointer registers.
   assumes the rom model answers the byte path. */
module info_space_base_field_ptr_cfg_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] OFS = 20'hA5C3E;
    logic clk = 1'h0, rst_b = 1'h0, busModeStrap = 1'h0, cfgWrite = 1'h0, cfgRead = 1'h0, romOffsetValid = 1'h0;
    logic memRead = 1'h0, extWindowHit, infoSpaceHit, romReadReq, romDataValid, memDataValid;
    logic [7:0] cfgAddr = 8'h0, romAddr, romData, memData;
    logic [3:0] cfgByteEn = 4'hF, lat = 4'h0;
    logic [4:0] romOffsetField = 5'h15;
    logic [31:0] cfgWrData = 32'h0, memAddr = 32'h0, cfgRdData, q;
    int failures = 0, n_compared = 0;
    info_space_base_field_ptr_cfg #(.OFS_UPPER(OFS)) uut(.*);
    cbp_rom rom(.*);
    always #2 clk = ~clk;
    task give_verdict;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task chk_hit(input logic g, e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task hits(input logic [31:0] ad, input logic eExt, input logic eInfo);
        @(posedge clk);
        memAddr <= ad;
        @(posedge clk);
        #1;
        chk_hit(extWindowHit, eExt);
        chk_hit(infoSpaceHit, eInfo);
    endtask
    task wrc(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk); cfgAddr <= ad; cfgWrData <= d; cfgByteEn <= b; cfgWrite <= 1'h1;
        @(posedge clk); cfgWrite <= 1'h0;
    endtask
    task rdc(input logic [7:0] ad);
        @(posedge clk); cfgAddr <= ad; cfgRead <= 1'h1;
        @(posedge clk); cfgRead <= 1'h0;
        @(posedge clk); #1 q = cfgRdData;
    endtask
    task mrd(input logic [31:0] ad, input logic [7:0] e);
        @(posedge clk); memAddr <= ad; memRead <= 1'h1;
        @(posedge clk); memRead <= 1'h0;
        repeat (20) begin @(posedge clk); #1 if (memDataValid === 1'h1) break; end
        chk({23'h0, memDataValid, memData}, {24'h1, e});
    endtask
    task t_reset;
        rdc(8'h14); chk(q, 32'h0);
        rdc(8'h28); chk(q, {4'h0, OFS, 5'h15, 3'h2});
        hits(32'h000007FF, 1'h1, 1'h0);
    endtask
    task t_ext;
        wrc(8'h14, 32'hFFFFFFFF, 4'hF); rdc(8'h14); chk(q, 32'hFFFFF800);
        wrc(8'h14, 32'h0, 4'h2); rdc(8'h14); chk(q, 32'hFFFF0000);
        wrc(8'h20, 32'hFFFFFFFF, 4'hF); rdc(8'h20); chk(q, 32'h0);
        hits(32'hFFFF07FF, 1'h1, 1'h0);
        hits(32'hFFFF0800, 1'h0, 1'h0);
    endtask
    task t_info;
        wrc(8'h18, 32'hFFFFFFFF, 4'hF); rdc(8'h18); chk(q, 32'hFFFFF800);
        mrd(32'hFFFFFAA5, 8'h5A);
        lat <= 4'h6; mrd(32'hFFFFF813, 8'hEC);
        hits(32'hFFFFF800, 1'h0, 1'h1);
        hits(32'hFFFFF000, 1'h0, 1'h0);
    endtask
    task t_high;
        @(posedge clk);
        busModeStrap <= 1'h1; rst_b <= 1'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        repeat (5) @(posedge clk);
        rdc(8'h14); chk(q, 32'h0);
        wrc(8'h18, 32'hFFFFFFFF, 4'hF); rdc(8'h18); chk(q, 32'h0);
        busModeStrap <= 1'h0; repeat (4) @(posedge clk);
        rdc(8'h28); chk(q, 32'h0);
        hits(32'h00000000, 1'h1, 1'h0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1; romOffsetValid <= 1'h1;
        @(posedge clk); romOffsetValid <= 1'h0;
        repeat (5) @(posedge clk);
        t_reset; t_ext; t_info; t_high;
        give_verdict;
    end
    // bench needs well under 200 cycles
    initial begin repeat (3000) @(posedge clk); failures++; give_verdict; end
endmodule // info_space_base_field_ptr_cfg_tb_top
